// File: verilog/ata_wr_device.sv
// Card end: task file, write command sequencer and data FIFO
// Functional notes
// RULE1: busy shows within 400 ns of command
// RULE2: block write interrupts per block, not sector
// RULE3: data request qualifies each block start only
// RULE4: block size limit one, shown in identify
// RULE5: host runs set-multiple before block writes
// RULE6: sector count register holds total sectors
// RULE7: remainder sectors form a final partial block
// RULE8: block write without multiple setting aborts
// RULE9: error stops at failing sector, no later blocks
// RULE10: data request and interrupt together per block
// RULE11: error leaves failing address and residual count
// RULE12: no-erase block write falls back to normal
// RULE13: sector write 1..256 sectors, zero means 256
// RULE14: busy, then data request, no first interrupt
// RULE15: host sends no data while busy
// RULE16: between sectors busy, then request plus interrupt
// RULE17: busy after last sector, then completion interrupt
// RULE18: sector write error keeps failing address
// RULE19: no-erase sector write falls back to normal
// RULE20: verify opcode checks each written sector
// RULE21: logical address spread over four registers
// RULE22: sector is 256 sixteen-bit words
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_s_valid,
   output logic o_s_ready,
   input wire logic [WIDTH-1:0] i_s_data,
   output logic o_m_valid,
   input wire logic i_m_ready,
   output logic [WIDTH-1:0] o_m_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign o_s_ready = cnt_q != CNT_FULL;
   assign o_m_valid = cnt_q != '0;
   assign o_m_data = mem_q[rp_q];
   assign push = i_s_valid && o_s_ready;
   assign pop = o_m_valid && i_m_ready;

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem_q[wp_q] <= i_s_data;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module ata_wr_device
   import ata_wr_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_WORDS,
   parameter logic [7:0] MAX_BLOCK = MAX_BLOCK_SECTORS
)
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   ata_wr_if.dev bus,
   output logic o_flash_valid,
   output logic [15:0] o_flash_data,
   input wire logic i_flash_ready,
   output logic [27:0] o_sector_lba,
   output logic o_sector_lba_mode,
   output logic o_sector_erase,
   output logic o_sector_verify,
   input wire logic i_sector_done,
   input wire logic i_sector_err
);
   typedef enum logic [2:0] {S_IDLE, S_BUSY, S_XFER, S_PROG, S_FLUSH,
      S_IDENT, S_FIN} dev_state_t;
   dev_state_t state_q;
   logic [7:0] feature_q, count_q, sector_q, trk_lo_q, trk_hi_q, dh_q;
   logic [7:0] op_q, err_q, mult_q, word_q, xfer_left_q, prog_left_q;
   logic [8:0] remain_q;
   logic multi_q, noerase_q, verify_q, intrq_q;
   logic [15:0] rdata_q;
   logic fifo_ready, fifo_valid, data_wr, blk_words_done;
   logic cmd_wr, tf_wr, refuse, is_write, go_busy, stat_rd;
   logic ok_done, bad_done, last_prog, ident_end;
   logic [8:0] bsz, blk_src;
   logic [7:0] blk_n;
   logic [27:0] lba_next;
   logic [7:0] wop;

   assign wop = bus.wdata[7:0];
   assign cmd_wr = bus.wr && bus.addr == REG_OPCODE && state_q == S_IDLE;
   assign tf_wr = bus.wr && state_q == S_IDLE;
   assign stat_rd = bus.rd && bus.addr == REG_OPCODE;
   assign is_write = wop == OP_WR_MULT || wop == OP_WR_MULT_NE ||
      wop == OP_WR_SEC || wop == OP_WR_SEC_RT || wop == OP_WR_SEC_NE ||
      wop == OP_WR_VERIFY;
   // Block writes need a prior multiple setting
   assign refuse = (wop == OP_WR_MULT || wop == OP_WR_MULT_NE) &&
      mult_q == MULT_RESET; // RULE8
   assign go_busy = (is_write && !refuse) || wop == OP_IDENTIFY;
   assign data_wr = bus.wr && bus.addr == REG_DATA && state_q == S_XFER
      && fifo_ready;
   assign blk_words_done = data_wr && word_q == WORD_LAST &&
      xfer_left_q == 8'h01; // RULE22
   assign ok_done = i_sector_done && !i_sector_err &&
      (state_q == S_XFER || state_q == S_PROG);
   assign bad_done = i_sector_done && i_sector_err &&
      (state_q == S_XFER || state_q == S_PROG);
   assign last_prog = ok_done && prog_left_q == 8'h01;
   assign ident_end = state_q == S_IDENT && bus.rd &&
      bus.addr == REG_DATA && word_q == WORD_LAST;
   // Block size is the multiple setting, or one sector for plain writes
   assign bsz = multi_q ? {1'b0, mult_q} : 9'h001; // RULE2
   assign blk_src = (state_q == S_BUSY) ? remain_q : remain_q - 9'h001;
   assign blk_n = (blk_src < bsz) ? blk_src[7:0] : bsz[7:0]; // RULE7
   assign lba_next = o_sector_lba + 28'h0000001;

   assign bus.bsy = state_q == S_BUSY || state_q == S_PROG ||
      state_q == S_FLUSH || state_q == S_FIN; // RULE1 RULE17
   assign bus.drq = state_q == S_XFER || state_q == S_IDENT; // RULE3
   assign bus.err = err_q != 8'h00;
   assign bus.intrq = intrq_q;
   assign bus.wready = fifo_ready && state_q == S_XFER;
   assign bus.rdata = rdata_q;
   assign o_sector_lba = {dh_q[3:0], trk_hi_q, trk_lo_q, sector_q}; // RULE21
   assign o_sector_lba_mode = dh_q[DH_LBA];
   // Backend falls back to erase-then-write for sectors not pre-erased
   assign o_sector_erase = !noerase_q; // RULE12 RULE19
   assign o_sector_verify = verify_q; // RULE20
   assign o_flash_valid = fifo_valid && state_q != S_FLUSH;

   word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_s_valid(data_wr),
      .o_s_ready(fifo_ready),
      .i_s_data(bus.wdata),
      .o_m_valid(fifo_valid),
      .i_m_ready(i_flash_ready || state_q == S_FLUSH),
      .o_m_data(o_flash_data)
   );

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         state_q <= S_IDLE;
      else
         unique case (state_q)
            S_IDLE: if (cmd_wr) state_q <= go_busy ? S_BUSY : S_FIN; // RULE1
            S_BUSY: state_q <= (op_q == OP_IDENTIFY) ? S_IDENT : S_XFER;
            S_XFER:
               if (bad_done)
                  state_q <= S_FLUSH; // RULE9
               else if (blk_words_done)
                  state_q <= S_PROG; // RULE16
            S_PROG:
               if (bad_done)
                  state_q <= S_FLUSH; // RULE9 RULE18
               else if (last_prog)
                  state_q <= (remain_q == 9'h001) ? S_FIN : S_XFER;
            S_FLUSH: if (!fifo_valid) state_q <= S_FIN;
            S_IDENT: if (ident_end) state_q <= S_FIN;
            S_FIN: state_q <= S_IDLE;
         endcase
   end

   // Interrupt: set wins over the status-read clear
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         intrq_q <= 1'b0;
      else if ((state_q == S_BUSY && (multi_q || op_q == OP_IDENTIFY)) ||
         (state_q == S_PROG && last_prog && remain_q != 9'h001) ||
         state_q == S_FIN)
         intrq_q <= 1'b1; // RULE10 RULE14 RULE16 RULE17
      else if (stat_rd || cmd_wr)
         intrq_q <= 1'b0;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         err_q <= 8'h00;
      else if (cmd_wr)
      begin
         err_q <= 8'h00;
         if (!go_busy && !(wop == OP_SET_MULT && count_q <= MAX_BLOCK))
            err_q[ERR_ABRT] <= 1'b1; // RULE8
      end
      else if (bad_done)
         err_q[ERR_MEDIA] <= 1'b1;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         feature_q <= 8'h00;
         count_q <= 8'h00;
         sector_q <= 8'h00;
         trk_lo_q <= 8'h00;
         trk_hi_q <= 8'h00;
         dh_q <= 8'h00;
      end
      else if (tf_wr)
         unique case (bus.addr)
            REG_FEATURE: feature_q <= wop;
            REG_COUNT: count_q <= wop; // RULE6
            REG_SECTOR: sector_q <= wop; // RULE21
            REG_TRK_LO: trk_lo_q <= wop;
            REG_TRK_HI: trk_hi_q <= wop;
            REG_DRVHEAD: dh_q <= wop;
            default: ;
         endcase
      else if (ok_done)
      begin
         // Residual count and address stay put on error
         count_q <= count_q - 8'h01; // RULE11
         if (remain_q != 9'h001)
            {dh_q[3:0], trk_hi_q, trk_lo_q, sector_q} <= lba_next;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         op_q <= 8'h00;
         multi_q <= 1'b0;
         noerase_q <= 1'b0;
         verify_q <= 1'b0;
         mult_q <= MULT_RESET;
      end
      else if (cmd_wr)
      begin
         op_q <= wop;
         multi_q <= wop == OP_WR_MULT || wop == OP_WR_MULT_NE;
         noerase_q <= wop == OP_WR_MULT_NE || wop == OP_WR_SEC_NE;
         verify_q <= wop == OP_WR_VERIFY;
         if (wop == OP_SET_MULT && count_q <= MAX_BLOCK)
            mult_q <= count_q; // RULE4
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         remain_q <= 9'h000;
         word_q <= 8'h00;
         xfer_left_q <= 8'h00;
         prog_left_q <= 8'h00;
      end
      else
      begin
         if (cmd_wr) // RULE13
            remain_q <= (count_q == 8'h00) ? FULL_COUNT : {1'b0, count_q};
         else if (ok_done)
            remain_q <= remain_q - 9'h001;
         if (state_q == S_BUSY || (state_q == S_PROG && last_prog))
         begin
            word_q <= 8'h00;
            xfer_left_q <= blk_n;
            prog_left_q <= blk_n;
         end
         else
         begin
            if (data_wr || (state_q == S_IDENT && bus.rd &&
               bus.addr == REG_DATA))
               word_q <= word_q + 8'h01;
            if (data_wr && word_q == WORD_LAST)
               xfer_left_q <= xfer_left_q - 8'h01;
            if (ok_done)
               prog_left_q <= prog_left_q - 8'h01;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         rdata_q <= 16'h0000;
      else if (bus.rd)
         unique case (bus.addr)
            REG_DATA:
               rdata_q <= (state_q == S_IDENT && word_q == IDENT_MULT_WORD)
                  ? {IDENT_MULT_FLAG, MAX_BLOCK} : 16'h0000; // RULE4
            REG_FEATURE: rdata_q <= {8'h00, err_q};
            REG_COUNT: rdata_q <= {8'h00, count_q};
            REG_SECTOR: rdata_q <= {8'h00, sector_q};
            REG_TRK_LO: rdata_q <= {8'h00, trk_lo_q};
            REG_TRK_HI: rdata_q <= {8'h00, trk_hi_q};
            REG_DRVHEAD: rdata_q <= {8'h00, dh_q};
            REG_OPCODE:
            begin
               rdata_q <= 16'h0000;
               rdata_q[ST_BSY] <= bus.bsy;
               rdata_q[ST_RDY] <= 1'b1;
               rdata_q[ST_DRQ] <= bus.drq;
               rdata_q[ST_ERR] <= bus.err;
            end
         endcase
   end
endmodule

// File: verilog/ata_wr_pkg.sv
// Shared constants for the sector-write command path
package ata_wr_pkg;
   // Task-file offsets
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_FEATURE = 3'h1;
   localparam logic [2:0] REG_COUNT = 3'h2;
   localparam logic [2:0] REG_SECTOR = 3'h3;
   localparam logic [2:0] REG_TRK_LO = 3'h4;
   localparam logic [2:0] REG_TRK_HI = 3'h5;
   localparam logic [2:0] REG_DRVHEAD = 3'h6;
   localparam logic [2:0] REG_OPCODE = 3'h7;
   // Opcodes
   localparam logic [7:0] OP_WR_MULT = 8'hC5;
   localparam logic [7:0] OP_WR_MULT_NE = 8'hCD;
   localparam logic [7:0] OP_WR_SEC = 8'h30;
   localparam logic [7:0] OP_WR_SEC_RT = 8'h31;
   localparam logic [7:0] OP_WR_SEC_NE = 8'h38;
   localparam logic [7:0] OP_WR_VERIFY = 8'h3C;
   localparam logic [7:0] OP_SET_MULT = 8'hC6;
   localparam logic [7:0] OP_IDENTIFY = 8'hEC;
   // Status, error and drive/head bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ERR_ABRT = 2;
   localparam int ERR_MEDIA = 6;
   localparam int DH_LBA = 6;
   // Sizes and reset values
   localparam logic [7:0] WORD_LAST = 8'hFF;
   localparam logic [8:0] FULL_COUNT = 9'h100;
   localparam logic [7:0] MAX_BLOCK_SECTORS = 8'h01;
   localparam logic [7:0] IDENT_MULT_WORD = 8'h2F;
   localparam logic [7:0] IDENT_MULT_FLAG = 8'h80;
   localparam logic [7:0] MULT_RESET = 8'h00;
   localparam int FIFO_WORDS = 8;
   // Busy must show within this time of command acceptance
   localparam int BSY_LIMIT_NS = 400;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BSY_LIMIT_CYC = BSY_LIMIT_NS * 1000 / CLK_PERIOD_PS;
endpackage

// File: verilog/ata_wr_if.sv
// Task-file link between the host controller and the card
`timescale 1ns/1ps
interface ata_wr_if;
   logic [2:0] addr;
   logic wr;
   logic rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic wready;
   logic bsy;
   logic drq;
   logic err;
   logic intrq;
   modport dev (input addr, wr, rd, wdata,
      output rdata, wready, bsy, drq, err, intrq);
   modport host (output addr, wr, rd, wdata,
      input rdata, wready, bsy, drq, err, intrq);
endinterface

// File: verilog/ata_wr_host.sv
// Host end: programs the task file and streams write data
`timescale 1ns/1ps
module ata_wr_host
   import ata_wr_pkg::*;
#(
   parameter logic [7:0] BLOCK_SECTORS = MAX_BLOCK_SECTORS
)
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   ata_wr_if.host bus,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_op,
   input wire logic [27:0] i_cmd_lba,
   input wire logic i_cmd_lba_mode,
   input wire logic [7:0] i_cmd_count,
   output logic o_cmd_ready,
   input wire logic i_data_valid,
   input wire logic [15:0] i_data,
   output logic o_data_ready,
   output logic o_done,
   output logic o_fail,
   output logic [7:0] o_error,
   output logic [7:0] o_residual,
   output logic [27:0] o_fail_lba
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_POLL, H_DATA, H_READ,
      H_END} host_state_t;
   host_state_t state_q;
   logic [7:0] op_q, count_q;
   logic [27:0] lba_q;
   logic mode_q, pre_q, mult_set_q, ph_q, done_q, fail_q;
   logic [2:0] step_q;
   logic [7:0] setup_byte;
   logic [7:0] err_q, resid_q;
   logic [27:0] flba_q;
   logic moving;

   assign o_cmd_ready = state_q == H_IDLE;
   assign o_done = done_q;
   assign o_fail = fail_q;
   assign o_error = err_q;
   assign o_residual = resid_q;
   assign o_fail_lba = flba_q;
   // Data only moves while the card requests it and is not busy
   assign moving = state_q == H_DATA && bus.drq && !bus.bsy; // RULE15 RULE3
   assign o_data_ready = moving && bus.wready;

   always_comb
   begin
      unique case (step_q)
         3'h0: setup_byte = pre_q ? BLOCK_SECTORS : count_q; // RULE6
         3'h1: setup_byte = lba_q[7:0];
         3'h2: setup_byte = lba_q[15:8];
         3'h3: setup_byte = lba_q[23:16];
         3'h4: setup_byte = {1'b1, mode_q, 2'b10, lba_q[27:24]}; // RULE21
         default: setup_byte = pre_q ? OP_SET_MULT : op_q; // RULE5
      endcase
   end

   always_comb
   begin
      bus.wr = 1'b0;
      bus.rd = 1'b0;
      bus.addr = REG_DATA;
      bus.wdata = 16'h0000;
      unique case (state_q)
         H_SETUP:
         begin
            bus.wr = 1'b1;
            bus.addr = step_q + REG_COUNT;
            bus.wdata = {8'h00, setup_byte};
         end
         H_POLL:
         begin
            bus.rd = bus.intrq;
            bus.addr = REG_OPCODE;
         end
         H_DATA:
         begin
            bus.wr = moving && i_data_valid;
            bus.wdata = i_data;
         end
         H_READ:
         begin
            bus.rd = !ph_q;
            bus.addr = step_q + REG_FEATURE;
         end
         default: ;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_q <= H_IDLE;
         step_q <= 3'h0;
         ph_q <= 1'b0;
         pre_q <= 1'b0;
         mult_set_q <= 1'b0;
      end
      else
         unique case (state_q)
            H_IDLE:
               if (i_cmd_valid)
               begin
                  state_q <= H_SETUP;
                  step_q <= 3'h0;
                  pre_q <= (i_cmd_op == OP_WR_MULT ||
                     i_cmd_op == OP_WR_MULT_NE) && !mult_set_q; // RULE5
               end
            H_SETUP:
               if (step_q == 3'h5)
                  state_q <= H_POLL;
               else
                  step_q <= step_q + 3'h1;
            H_POLL:
               if (!bus.bsy && bus.drq)
                  state_q <= H_DATA;
               else if (!bus.bsy)
               begin
                  step_q <= 3'h0;
                  ph_q <= 1'b0;
                  if (bus.err)
                     state_q <= H_READ;
                  else if (pre_q)
                  begin
                     pre_q <= 1'b0;
                     mult_set_q <= 1'b1;
                     state_q <= H_SETUP;
                  end
                  else
                     state_q <= H_END;
               end
            H_DATA: if (!bus.drq || bus.bsy) state_q <= H_POLL;
            H_READ:
            begin
               ph_q <= !ph_q;
               if (ph_q && step_q == 3'h5)
                  state_q <= H_END;
               else if (ph_q)
                  step_q <= step_q + 3'h1;
            end
            H_END: state_q <= H_IDLE;
         endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         op_q <= 8'h00;
         count_q <= 8'h00;
         lba_q <= 28'h0000000;
         mode_q <= 1'b0;
      end
      else if (state_q == H_IDLE && i_cmd_valid)
      begin
         op_q <= i_cmd_op;
         count_q <= i_cmd_count;
         lba_q <= i_cmd_lba;
         mode_q <= i_cmd_lba_mode;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
         err_q <= 8'h00;
         resid_q <= 8'h00;
         flba_q <= 28'h0000000;
      end
      else
      begin
         done_q <= state_q == H_END;
         if (state_q == H_IDLE && i_cmd_valid)
            fail_q <= 1'b0;
         else if (state_q == H_POLL && !bus.bsy && !bus.drq && bus.err)
            fail_q <= 1'b1;
         if (state_q == H_READ && ph_q)
            unique case (step_q)
               3'h0: err_q <= bus.rdata[7:0];
               3'h1: resid_q <= bus.rdata[7:0]; // RULE11
               3'h2: flba_q[7:0] <= bus.rdata[7:0]; // RULE18
               3'h3: flba_q[15:8] <= bus.rdata[7:0];
               3'h4: flba_q[23:16] <= bus.rdata[7:0];
               default: flba_q[27:24] <= bus.rdata[3:0];
            endcase
      end
   end
endmodule

// File: bench/ata_wr_monitor.sv
// Checker on the task-file link between host and card
`timescale 1ns/1ps
module ata_wr_monitor
   import ata_wr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [2:0] addr,
   input wire logic wr,
   input wire logic [15:0] wdata,
   input wire logic wready,
   input wire logic bsy,
   input wire logic drq,
   input wire logic err,
   input wire logic intrq
);
   logic [7:0] op_q;
   logic first_q;
   logic mset_q;
   logic [7:0] wc_q;
   logic cmd_w;
   logic sec_w;
   logic mul_w;
   assign cmd_w = wr && addr == REG_OPCODE && !bsy && !drq;
   assign mul_w = op_q == OP_WR_MULT || op_q == OP_WR_MULT_NE;
   assign sec_w = op_q == OP_WR_SEC || op_q == OP_WR_SEC_RT ||
      op_q == OP_WR_SEC_NE || op_q == OP_WR_VERIFY;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         op_q <= 8'h00;
         first_q <= 1'b0;
         mset_q <= 1'b0;
      end
      else if (cmd_w)
      begin
         op_q <= wdata[7:0];
         first_q <= 1'b1;
         if (wdata[7:0] == OP_SET_MULT)
            mset_q <= 1'b1;
      end
      else if (drq)
         first_q <= 1'b0;
   end
   // Data words counted modulo 256 across the run, must wrap to zero on every sector
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         wc_q <= 8'h00;
      else if (wr && addr == REG_DATA && wready && drq)
         wc_q <= wc_q + 8'h01;
   end
   bsy_on_cmd_a: assert property (cmd_w |=> bsy)
      else $error("busy missing after command");
   no_data_busy_a: assert property
      (wr && addr == REG_DATA |-> drq && !bsy)
      else $error("data written outside request");
   // The host end must program the block size before any block write
   blk_after_set_a: assert property
      (cmd_w && (wdata[7:0] == OP_WR_MULT || wdata[7:0] == OP_WR_MULT_NE)
      |-> mset_q)
      else $error("block write before multiple setting");
   drq_bsy_excl_a: assert property (!(bsy && drq))
      else $error("busy and request together");
   first_no_int_a: assert property
      ($rose(drq) && first_q && sec_w |-> !intrq ##1 !intrq)
      else $error("interrupt before first sector");
   sec_next_int_a: assert property
      ($rose(drq) && !first_q && sec_w |-> ##[0:1] intrq)
      else $error("no interrupt on next sector");
   blk_int_a: assert property ($rose(drq) && mul_w |-> ##[0:1] intrq)
      else $error("no interrupt at block start");
   sector_words_a: assert property
      ($fell(drq) |-> wc_q == 8'h00 && bsy)
      else $error("sector not whole or not busy");
   done_int_a: assert property ($fell(bsy) && !drq |-> ##[0:1] intrq)
      else $error("no completion interrupt");
   cover property ($rose(drq) && mul_w);
   cover property ($rose(err));
   cover property ($fell(bsy) && !drq && !err);
endmodule

// File: bench/ata_write_command_protocol_tb.sv
// Bench: host and card joined, user and backend sides modelled
`timescale 1ns/1ps
module ata_write_command_protocol_tb;
   import ata_wr_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic cmd_valid = 1'b0, cmd_mode = 1'b0, dv = 1'b0, f_ready = 1'b0;
   logic s_done = 1'b0, s_err = 1'b0, data_en = 1'b0;
   logic cmd_ready, d_ready, done, fail, f_valid, s_mode, s_erase, s_ver;
   logic x_erase, x_ver, x_mode;
   logic [7:0] cmd_op = 8'h00, cmd_cnt = 8'h00, h_err, h_res;
   logic [27:0] cmd_lba = 28'h0000000, h_lba, s_lba, exp_lba;
   logic [15:0] dw = 16'h0000, f_data;
   logic [31:0] seed = 32'h2929, r_src, r_bk;
   int fails = 0, samples_checked = 0, wc = 0, sec_n = 0, err_at = -1;
   logic [15:0] exp_q[$];
   always #2.5 i_ref_clk = ~i_ref_clk;
   ata_wr_if link();
   ata_wr_device ata_wr_device_inst (.i_ref_clk(i_ref_clk),
      .i_reset(i_reset), .bus(link), .o_flash_valid(f_valid),
      .o_flash_data(f_data), .i_flash_ready(f_ready), .o_sector_lba(s_lba),
      .o_sector_lba_mode(s_mode), .o_sector_erase(s_erase),
      .o_sector_verify(s_ver), .i_sector_done(s_done), .i_sector_err(s_err));
   ata_wr_host ata_wr_host_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .bus(link), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
      .i_cmd_lba(cmd_lba), .i_cmd_lba_mode(cmd_mode),
      .i_cmd_count(cmd_cnt), .o_cmd_ready(cmd_ready), .i_data_valid(dv),
      .i_data(dw), .o_data_ready(d_ready), .o_done(done), .o_fail(fail),
      .o_error(h_err), .o_residual(h_res), .o_fail_lba(h_lba));
   ata_wr_monitor ata_wr_monitor_inst (.i_ref_clk(i_ref_clk),
      .i_reset(i_reset), .addr(link.addr), .wr(link.wr),
      .wdata(link.wdata), .wready(link.wready), .bsy(link.bsy),
      .drq(link.drq), .err(link.err), .intrq(link.intrq));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input string what, input logic [27:0] exp,
      input logic [27:0] got);
      samples_checked++;
      if (exp !== got)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task stop_test();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Host user side: random gaps exercise stalls on the data register
   always @(posedge i_ref_clk)
   begin
      r_src = rnd();
      if (dv && d_ready)
         exp_q.push_back(dw);
      if (!dv || d_ready)
      begin
         dv <= data_en && r_src[0];
         dw <= r_src[31:16];
      end
   end
   // Flash backend: stalls at random so the FIFO fills and refuses
   always @(posedge i_ref_clk)
   begin
      r_bk = rnd();
      f_ready <= r_bk[1] | r_bk[2];
      s_done <= 1'b0;
      s_err <= 1'b0;
      if (f_valid && f_ready)
      begin
         chk("flash word", exp_q.pop_front(), f_data);
         wc++;
         if (wc == 256)
         begin
            wc = 0;
            s_done <= 1'b1;
            s_err <= (sec_n == err_at);
            chk("sector address", exp_lba, s_lba);
            chk("erase", x_erase, s_erase);
            chk("verify", x_ver, s_ver);
            chk("address mode", x_mode, s_mode);
            exp_lba++;
            sec_n++;
         end
      end
   end
   task run_cmd(input logic [7:0] op, input logic [27:0] logical_addressing_select,
      input logic [7:0] cnt, input logic mode, input int bad);
      int n;
      int t;
      int ns;
      n = (cnt == 8'h00) ? 256 : int'(cnt);
      // bad: -1 clean, -2 refused with abort, else failing sector index
      ns = (bad >= 0) ? bad + 1 : n;
      if (bad < -1 || op == OP_SET_MULT)
         ns = 0;
      err_at = bad;
      exp_lba = logical_addressing_select;
      sec_n = 0;
      x_erase = !(op == OP_WR_SEC_NE || op == OP_WR_MULT_NE);
      x_ver = (op == OP_WR_VERIFY);
      x_mode = mode;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_lba <= logical_addressing_select;
      cmd_cnt <= cnt;
      cmd_mode <= mode;
      data_en <= 1'b1;
      t = 0;
      do
      begin
         @(posedge i_ref_clk);
         t++;
      end
      while (cmd_ready !== 1'b1 && t < 100);
      cmd_valid <= 1'b0;
      t = 0;
      do
      begin
         @(posedge i_ref_clk);
         t++;
      end
      while (done !== 1'b1 && t < 1000 * n + 500);
      data_en <= 1'b0;
      chk("done", 1'b1, done);
      chk("fail", bad != -1, fail);
      chk("sectors", ns, sec_n);
      if (bad != -1)
         chk("abort", bad < -1, h_err[ERR_ABRT]);
      if (bad >= 0)
      begin
         chk("residual", n - bad, h_res);
         chk("fail address", logical_addressing_select + bad, h_lba);
         chk("media error", 1'b1, h_err[ERR_MEDIA]);
      end
      repeat (4) @(posedge i_ref_clk);
      exp_q.delete();
      wc = 0;
   endtask
   initial
   begin
      repeat (8) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      run_cmd(OP_WR_SEC, 28'hABCDEF1, 8'h01, 1'b1, -1);
      run_cmd(OP_WR_SEC_RT, 28'h00000FE, 8'h03, 1'b0, -1);
      run_cmd(OP_WR_SEC_NE, 28'h1234567, 8'h02, 1'b1, -1);
      run_cmd(OP_WR_VERIFY, 28'h7654321, 8'h03, 1'b1, 1);
      run_cmd(OP_WR_MULT, 28'h0001000, 8'h03, 1'b1, -1);
      run_cmd(OP_WR_MULT_NE, 28'hFFFFFFD, 8'h04, 1'b0, 2);
      run_cmd(OP_SET_MULT, 28'h0000000, 8'h02, 1'b0, -2);
      run_cmd(OP_SET_MULT, 28'h0000000, 8'h00, 1'b0, -1);
      run_cmd(OP_WR_MULT, 28'h0000010, 8'h02, 1'b1, -2);
      stop_test();
   end
   // Whole run needs some 7500 cycles
   initial
   begin
      repeat (40000) @(posedge i_ref_clk);
      chk("watchdog", 1'b1, 1'b0);
      stop_test();
   end
endmodule
